// ---- design/ppo_top.v ----
// Purpose: pulse pattern output bank, sixteen pins in four groups loaded by timer triggers
// Assumes: trigger inputs come from the timer unit on the same clock as single-cycle pulses
// Notes: the pins are plain outputs; direction control lives in the port logic outside
`timescale 1ns/100ps
`include "ppo_regs.vh"

module ppo_top #(
	parameter NUM_TRIG = 4
) (
	input  wire                   CLK,
	input  wire                   RESET_N,
	input  wire [`PPO_ADDR_W-1:0] ADDR,
	input  wire [7:0]             WDATA,
	input  wire                   WR,
	input  wire                   RD,
	output reg  [7:0]             RDATA,
	input  wire [NUM_TRIG-1:0]    TRIG,
	output wire [15:0]            PULSE_OUT
);

	// four groups of four bits each
	localparam GROUPS  = 4;
	localparam GROUP_W = 4;
	localparam BYTE_W  = 8;
	localparam TSEL_N  = `PPO_TSEL_W * GROUPS;

	// address hits, qualified by the strobes below
	wire                        hit_enable_high;
	wire                        hit_enable_low;
	wire                        hit_level_high;
	wire                        hit_level_low;
	wire                        hit_staged_high;
	wire                        hit_staged_low;
	wire                        hit_trig_sel;

	wire                        wr_enable_high;
	wire                        wr_enable_low;
	wire                        wr_level_high;
	wire                        wr_level_low;
	wire                        wr_staged_high;
	wire                        wr_staged_low;
	wire                        wr_trig_sel;

	// trigger routing
	reg  [TSEL_N-1:0]           tsel_reg;
	reg  [TSEL_N-1:0]           tsel_next;
	wire [NUM_TRIG+GROUP_W-1:0] trig_pad;
	wire [GROUP_W-1:0]          trig_ext;
	wire [GROUPS-1:0]           fire;

	// group 3 down to group 0
	wire [GROUP_W-1:0]          enable_g3;
	wire [GROUP_W-1:0]          enable_g2;
	wire [GROUP_W-1:0]          enable_g1;
	wire [GROUP_W-1:0]          enable_g0;
	wire [GROUP_W-1:0]          staged_g3;
	wire [GROUP_W-1:0]          staged_g2;
	wire [GROUP_W-1:0]          staged_g1;
	wire [GROUP_W-1:0]          staged_g0;
	wire [GROUP_W-1:0]          level_g3;
	wire [GROUP_W-1:0]          level_g2;
	wire [GROUP_W-1:0]          level_g1;
	wire [GROUP_W-1:0]          level_g0;

	wire [15:0]                 enable_all;
	wire [15:0]                 staged_all;
	wire [15:0]                 level_all;

	// register read back
	reg  [BYTE_W-1:0]           rdata_next;

	assign hit_enable_high = (ADDR == `PPO_OFF_ENABLE_HIGH);
	assign hit_enable_low  = (ADDR == `PPO_OFF_ENABLE_LOW);
	assign hit_level_high  = (ADDR == `PPO_OFF_LEVEL_HIGH);
	assign hit_level_low   = (ADDR == `PPO_OFF_LEVEL_LOW);
	assign hit_staged_high = (ADDR == `PPO_OFF_STAGED_HIGH);
	assign hit_staged_low  = (ADDR == `PPO_OFF_STAGED_LOW);
	assign hit_trig_sel    = (ADDR == `PPO_OFF_TRIG_SEL);

	// a write never lands on two registers at once
	assign wr_enable_high  = WR && hit_enable_high;
	assign wr_enable_low   = WR && hit_enable_low;
	assign wr_level_high   = WR && hit_level_high;
	assign wr_level_low    = WR && hit_level_low;
	assign wr_staged_high  = WR && hit_staged_high;
	assign wr_staged_low   = WR && hit_staged_low;
	assign wr_trig_sel     = WR && hit_trig_sel;

	// select codes beyond the trigger count pick a constant-low line
	assign trig_pad = {{GROUP_W{1'b0}}, TRIG};
	assign trig_ext = trig_pad[GROUP_W-1:0];

	// trigger select register
	always @* begin
		tsel_next = tsel_reg;
		if (wr_trig_sel) begin
			tsel_next = WDATA;
		end
	end

	always @(posedge CLK) begin
		if (!RESET_N) begin
			tsel_reg <= `PPO_RST_BYTE;
		end else begin
			tsel_reg <= tsel_next;
		end
	end

	// one trigger per group; groups sharing a code move together
	ppo_trig_pick #(
		.SEL_W (`PPO_TSEL_W)
	) pick3_u (
		.trig  (trig_ext),
		.sel   (tsel_reg[7:6]),
		.fire  (fire[3])
	);

	ppo_trig_pick #(
		.SEL_W (`PPO_TSEL_W)
	) pick2_u (
		.trig  (trig_ext),
		.sel   (tsel_reg[5:4]),
		.fire  (fire[2])
	);

	ppo_trig_pick #(
		.SEL_W (`PPO_TSEL_W)
	) pick1_u (
		.trig  (trig_ext),
		.sel   (tsel_reg[3:2]),
		.fire  (fire[1])
	);

	ppo_trig_pick #(
		.SEL_W (`PPO_TSEL_W)
	) pick0_u (
		.trig  (trig_ext),
		.sel   (tsel_reg[1:0]),
		.fire  (fire[0])
	);

	// group 3 on bits 15-12 down to group 0 on bits 3-0
	ppo_group #(
		.WIDTH     (GROUP_W)
	) group3_u (
		.clk       (CLK),
		.reset_n   (RESET_N),
		.fire      (fire[3]),
		.wr_enable (wr_enable_high),
		.wr_staged (wr_staged_high),
		.wr_level  (wr_level_high),
		.wdata     (WDATA[7:4]),
		.enable    (enable_g3),
		.staged    (staged_g3),
		.level     (level_g3)
	);

	ppo_group #(
		.WIDTH     (GROUP_W)
	) group2_u (
		.clk       (CLK),
		.reset_n   (RESET_N),
		.fire      (fire[2]),
		.wr_enable (wr_enable_high),
		.wr_staged (wr_staged_high),
		.wr_level  (wr_level_high),
		.wdata     (WDATA[3:0]),
		.enable    (enable_g2),
		.staged    (staged_g2),
		.level     (level_g2)
	);

	ppo_group #(
		.WIDTH     (GROUP_W)
	) group1_u (
		.clk       (CLK),
		.reset_n   (RESET_N),
		.fire      (fire[1]),
		.wr_enable (wr_enable_low),
		.wr_staged (wr_staged_low),
		.wr_level  (wr_level_low),
		.wdata     (WDATA[7:4]),
		.enable    (enable_g1),
		.staged    (staged_g1),
		.level     (level_g1)
	);

	ppo_group #(
		.WIDTH     (GROUP_W)
	) group0_u (
		.clk       (CLK),
		.reset_n   (RESET_N),
		.fire      (fire[0]),
		.wr_enable (wr_enable_low),
		.wr_staged (wr_staged_low),
		.wr_level  (wr_level_low),
		.wdata     (WDATA[3:0]),
		.enable    (enable_g0),
		.staged    (staged_g0),
		.level     (level_g0)
	);

	assign enable_all = {enable_g3, enable_g2, enable_g1, enable_g0};
	assign staged_all = {staged_g3, staged_g2, staged_g1, staged_g0};
	assign level_all  = {level_g3, level_g2, level_g1, level_g0};

	// read mux, sampled into RDATA on the read strobe
	always @* begin
		case (ADDR)
			`PPO_OFF_ENABLE_HIGH: rdata_next = enable_all[15:8];
			`PPO_OFF_ENABLE_LOW:  rdata_next = enable_all[7:0];
			`PPO_OFF_LEVEL_HIGH:  rdata_next = level_all[15:8];
			`PPO_OFF_LEVEL_LOW:   rdata_next = level_all[7:0];
			`PPO_OFF_STAGED_HIGH: rdata_next = staged_all[15:8];
			`PPO_OFF_STAGED_LOW:  rdata_next = staged_all[7:0];
			`PPO_OFF_TRIG_SEL:    rdata_next = tsel_reg;
			default:              rdata_next = `PPO_READ_UNMAPPED;
		endcase
	end

	// read data stand for one cycle only, zero otherwise
	always @(posedge CLK) begin
		if (!RESET_N) begin
			RDATA <= `PPO_RST_BYTE;
		end else if (RD) begin
			RDATA <= rdata_next;
		end else begin
			RDATA <= `PPO_RST_BYTE;
		end
	end

	// pins are plain outputs; the port direction lives outside
	assign PULSE_OUT = level_all;

endmodule // ppo_top

// Purpose: picks the trigger line named by one group's select field
// Assumes: trigger lines are single-cycle pulses on the block clock
// Notes: purely combinational, the group register samples the result
module ppo_trig_pick #(
	parameter SEL_W = 2
) (
	input  wire [(1<<SEL_W)-1:0] trig,
	input  wire [SEL_W-1:0]      sel,
	output wire                  fire
);

	assign fire = trig[sel];

endmodule // ppo_trig_pick

// Purpose: one pulse group: enable, staged value and output level bits
// Assumes: fire is already the group's selected trigger, on the same clock
// Notes: trigger and level write in one cycle leave enabled bits to the trigger
module ppo_group #(
	parameter WIDTH = 4
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire             fire,
	input  wire             wr_enable,
	input  wire             wr_staged,
	input  wire             wr_level,
	input  wire [WIDTH-1:0] wdata,
	output wire [WIDTH-1:0] enable,
	output wire [WIDTH-1:0] staged,
	output wire [WIDTH-1:0] level
);

	reg  [WIDTH-1:0] enable_reg;
	reg  [WIDTH-1:0] enable_next;
	reg  [WIDTH-1:0] staged_reg;
	reg  [WIDTH-1:0] staged_next;
	reg  [WIDTH-1:0] level_reg;
	reg  [WIDTH-1:0] level_cpu;
	reg  [WIDTH-1:0] level_next;

	assign enable = enable_reg;
	assign staged = staged_reg;
	assign level  = level_reg;

	// enable bits follow processor writes only
	always @* begin
		enable_next = enable_reg;
		if (wr_enable) begin
			enable_next = wdata;
		end
	end

	// staged value follows processor writes only
	always @* begin
		staged_next = staged_reg;
		if (wr_staged) begin
			staged_next = wdata;
		end
	end

	// processor writes reach only the bits that are not enabled
	always @* begin
		level_cpu = level_reg;
		if (wr_level) begin
			level_cpu = (level_reg & enable_reg) | (wdata & ~enable_reg);
		end
	end

	// the trigger loads enabled bits from the staged value, disabled bits hold
	always @* begin
		level_next = level_cpu;
		if (fire) begin
			level_next = (level_cpu & ~enable_reg) | (staged_reg & enable_reg);
		end
	end

	// enable register
	always @(posedge clk) begin
		if (!reset_n) begin
			enable_reg <= {WIDTH{1'b0}};
		end else begin
			enable_reg <= enable_next;
		end
	end

	// staged register
	always @(posedge clk) begin
		if (!reset_n) begin
			staged_reg <= {WIDTH{1'b0}};
		end else begin
			staged_reg <= staged_next;
		end
	end

	// level moves only on a write or a timer trigger
	always @(posedge clk) begin
		if (!reset_n) begin
			level_reg <= {WIDTH{1'b0}};
		end else begin
			level_reg <= level_next;
		end
	end

endmodule // ppo_group

// ---- design/ppo_regs.vh ----
// Purpose: register map, field layout and reset values of the pulse pattern output block
// Assumes: 8-bit register port, one register per address
// Notes: Functional notes list every behaviour the block keeps
//
// Functional notes
// - sixteen pulse bits form four 4-bit groups, 3 down to 0, each updating together or on its own.
// - bits 15-12 are group 3, 11-8 group 2, 7-4 group 1, 3-0 group 0, all outputs only.
// - transfer timing comes from trigger events of the 16-bit timer unit.
// - an enabled high-half bit copies its staged value into its output bit on the selected trigger.
// - an enabled low-half bit copies its staged value into its output bit on the selected trigger.
// - a disabled bit keeps its output value on a trigger.
// - an output bit enabled for pulse output ignores processor writes.
// - a high output bit whose enable is clear takes processor writes, setting the initial level.
// - each pulse pin shows its output data bit.
// - an enabled low output bit ignores processor writes while triggers still load it.
// - each group uses the trigger chosen by its field in the trigger select register.
`ifndef PPO_REGS_VH
`define PPO_REGS_VH

`define PPO_ADDR_W          4
`define PPO_OFF_ENABLE_HIGH 4'h0
`define PPO_OFF_ENABLE_LOW  4'h1
`define PPO_OFF_LEVEL_HIGH  4'h2
`define PPO_OFF_LEVEL_LOW   4'h3
`define PPO_OFF_STAGED_HIGH 4'h4
`define PPO_OFF_STAGED_LOW  4'h5
`define PPO_OFF_TRIG_SEL    4'h6

// trigger select: 2 bits per group, group g at bits 2g+1:2g
`define PPO_TSEL_W          2
`define PPO_RST_BYTE        8'h00
`define PPO_READ_UNMAPPED   8'h00

`endif

// ---- sim/ppo_top_properties.sv ----
// Purpose: port checks on ppo_top. Assumes: one clock. Notes: bound from the bench top
`timescale 1ns/100ps
module ppo_top_properties #(parameter NUM_TRIG=4)(
	input wire logic CLK,RESET_N,WR,RD,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,RDATA,
	input wire logic [NUM_TRIG-1:0] TRIG,
	input wire logic [15:0] PULSE_OUT);
default clocking @(posedge CLK);endclocking
default disable iff (!RESET_N);
sequence quiet;!WR&&TRIG==0;endsequence
a_pins_hold: assert property(quiet|=>$stable(PULSE_OUT))else $error("pins moved");
a_rdata_idle: assert property(!RD|=>RDATA==8'h00)else $error("rdata not idle");
a_unmapped_zero: assert property(RD&&ADDR>6|=>RDATA==8'h00)else $error("unmapped read");
sequence high_freed;WR&&ADDR==4'h0&&WDATA==8'h00 ##1 (!WR)[*2] ##0 TRIG!=0;endsequence
a_reset_low: assert property(disable iff(1'b0) !RESET_N|=>PULSE_OUT==16'h0000)else $error("pins not low");
a_read_high: assert property(RD&&ADDR==4'h2|=>RDATA==$past(PULSE_OUT[15:8]))else $error("high readback");
a_read_low: assert property(RD&&ADDR==4'h3|=>RDATA==$past(PULSE_OUT[7:0]))else $error("low readback");
a_high_freed: assert property(high_freed|=>$stable(PULSE_OUT[15:8]))else $error("disabled bits moved");
endmodule // ppo_top_properties

// ---- sim/ppo_pin_sink.sv ----
// Purpose: load on the pulse pins. Assumes: pins set to output. Notes: registers what it sees
`timescale 1ns/100ps
module ppo_pin_sink(input wire logic CLK,input wire logic [15:0] PINS,output logic [15:0] seen);
always @(posedge CLK) seen<=PINS;
endmodule // ppo_pin_sink

// ---- sim/tb_ppo_top.sv ----
// Purpose: bench for ppo_top. Assumes: one clock. Notes: hand-written scenarios
`timescale 1ns/100ps
module tb_ppo_top;
logic CLK=0,RESET_N=0,WR=0,RD=0;
logic [3:0] ADDR=0,TRIG=0;
logic [7:0] WDATA=0,RDATA;
logic [15:0] PULSE_OUT,seen;
int miscompares=0,compares=0,cyc=0;
ppo_top dut_u(.CLK(CLK),.RESET_N(RESET_N),.ADDR(ADDR),.WDATA(WDATA),.WR(WR),.RD(RD),.RDATA(RDATA),.TRIG(TRIG),
	.PULSE_OUT(PULSE_OUT));
ppo_pin_sink sink_u(.CLK(CLK),.PINS(PULSE_OUT),.seen(seen));
initial forever #5 CLK=~CLK;
always @(posedge CLK) if(++cyc==3000) begin miscompares++;complete_run;end
task complete_run;
	$display("compares %0d miscompares %0d",compares,miscompares);
	if(miscompares==0&&compares>0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
task chk(string n,logic [15:0] s,logic [15:0] e);compares++;
	if(s!==e) begin miscompares++;$display("[FAIL] %s exp %h got %h",n,e,s);end
endtask
task wr(logic [3:0] a,logic [7:0] d);@(posedge CLK);ADDR<=a;WDATA<=d;WR<=1;@(posedge CLK);WR<=0;#1;endtask
task rd(logic [3:0] a,logic [7:0] e);@(posedge CLK);ADDR<=a;RD<=1;@(posedge CLK);RD<=0;#1 chk("rdata",RDATA,e);endtask
task trig(logic [3:0] t);@(posedge CLK);TRIG<=t;@(posedge CLK);TRIG<=0;#1;endtask
task t_reset;
	rd(0,0);rd(1,0);rd(2,0);
	chk("pins",PULSE_OUT,0);
endtask
task t_high;
	wr(2,8'hA5);chk("pins",PULSE_OUT,16'hA500);
	wr(0,8'h0F);wr(4,8'h3C);wr(6,0);trig(1);chk("pins",PULSE_OUT,16'hAC00);
	wr(2,0);chk("pins",PULSE_OUT,16'h0C00);
	wr(0,0);trig(1);chk("pins",PULSE_OUT,16'h0C00);
endtask
task t_low;
	wr(1,8'hFF);wr(5,8'h5A);wr(6,8'h01);trig(2);chk("pins",PULSE_OUT,16'h0C0A);
	wr(3,8'hFF);rd(3,8'h0A);
	rd(7,0);
	trig(1);chk("pins",PULSE_OUT,16'h0C5A);
	@(posedge CLK);#1 chk("seen",seen,16'h0C5A);
endtask
initial begin repeat(8) @(posedge CLK);RESET_N<=1;t_reset;t_high;t_low;complete_run;end
endmodule // tb_ppo_top
bind ppo_top ppo_top_properties #(.NUM_TRIG(NUM_TRIG)) prop_u(.CLK,.RESET_N,.WR,.RD,.ADDR,.WDATA,.RDATA,.TRIG,.PULSE_OUT);
